// ### design/fp_product.sv
// Combinational float product with flush-to-zero and selectable zero rule
`timescale 1ns/10ps
module fp_product #(
  parameter int EXP_W = 8,
  parameter int MAN_W = 23
) (
  input  wire logic [EXP_W+MAN_W:0] opA,
  input  wire logic [EXP_W+MAN_W:0] opB,
  input  wire logic                 ieeeZero,
  output logic      [EXP_W+MAN_W:0] prod
);
  localparam int W = EXP_W + MAN_W + 1;
  localparam logic [EXP_W-1:0] EMAX = '1;
  localparam logic [EXP_W+1:0] BIAS = (EXP_W+2)'((1 << (EXP_W - 1)) - 1);
  localparam logic [W-1:0] QNAN = {1'b1, EMAX, 1'b1, {(MAN_W-1){1'b0}}};

  if (EXP_W < 3 || MAN_W < 2) begin : g_chk
    $error("fp_product: field widths too small");
  end

  logic                   sA, sB, sP;
  logic [EXP_W-1:0]       eA, eB;
  logic [MAN_W-1:0]       mA, mB, mP;
  logic                   zA, zB, infA, infB, nanA, nanB, norm;
  logic [2*MAN_W+1:0]     mant;
  logic signed [EXP_W+1:0] eSum;

  assign {sA, eA, mA} = opA;
  assign {sB, eB, mB} = opB;
  assign sP   = sA ^ sB;
  // Denormals count as zero
  assign zA   = (eA == '0);
  assign zB   = (eB == '0);
  assign infA = (eA == EMAX) && (mA == '0);
  assign infB = (eB == EMAX) && (mB == '0);
  assign nanA = (eA == EMAX) && (mA != '0);
  assign nanB = (eB == EMAX) && (mB != '0);
  assign mant = {1'b1, mA} * {1'b1, mB};
  assign norm = mant[2*MAN_W+1];
  assign mP   = norm ? mant[2*MAN_W:MAN_W+1] : mant[2*MAN_W-1:MAN_W];
  assign eSum = $signed({2'b00, eA}) + $signed({2'b00, eB}) - $signed(BIAS)
              + $signed({{(EXP_W+1){1'b0}}, norm});

  // Mantissa is truncated; no rounding stage to keep the path short
  always_comb
  begin
    if (!ieeeZero && (zA || zB))
      prod = {sP, {(W-1){1'b0}}};
    else if (nanA)
      prod = opA;
    else if (nanB)
      prod = opB;
    else if ((infA && zB) || (zA && infB))
      prod = QNAN;
    else if (zA || zB)
      prod = {sP, {(W-1){1'b0}}};
    else if (infA || infB || eSum >= $signed({2'b00, EMAX}))
      prod = {sP, EMAX, {MAN_W{1'b0}}};
    else if (eSum <= 0)
      prod = {sP, {(W-1){1'b0}}};
    else
      prod = {sP, eSum[EXP_W-1:0], mP};
  end

endmodule // fp_product

// ### design/gpu_multiply_alu.sv
// Multiply-family execution for one four-slot ALU instruction group
// Function
// - Two-operand opcode 1 is the single-precision product of sources 0 and 1.
// - Basic product returns zero when either source is zero, even with inf/NaN.
// - Double product takes sources from Y:X pairs, low 64 bits go to Y:X.
// - Double product flushes denormals, gives quiet NaN for inf*0, propagates src0 NaN.
// - Opcodes 27 and 202 both decode as the double-precision product.
// - Double result low dword goes to X and Z, high dword to Y and W.
// - Double source sign modifiers come from the Y slot only.
// - Double output modifiers are honoured only from the X or Z slot.
// - Opcode 2 is the product with IEEE zero rules, zero times inf gives NaN.
// - Opcode 209 multiplies source 1 by the W (for Y) or Z (for X) product.
// - Forwarded W/Z product skips that slot's output modifier and clamp.
// - Opcode 210 is the chained product with IEEE zero rules.
// - Lighting op 31 gives most negative float on bad inputs, replicated.
// - Opcode 181 multiplies low 24 bits of each source, low 32 bits out.
// - Three-operand opcode 20 is product plus third source.
// - Three-operand opcode 23 is product plus third source, then halved.
// - Three-operand opcode 24 is IEEE product plus third source.
// - IEEE chained op uses the neighbour's plain product without its modifiers.
// - Two-operand opcode 213 is the IEEE chained product, with no add.
`timescale 1ns/10ps
module gpu_multiply_alu
  import mul_alu_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic                   issueValid,
  input  wire logic [SLOTS-1:0]       opThree,
  input  wire logic [SLOTS-1:0][10:0] opcodeField,
  input  wire logic [SLOTS-1:0][31:0] src0,
  input  wire logic [SLOTS-1:0][31:0] src1,
  input  wire logic [SLOTS-1:0][31:0] src2,
  input  wire logic [SLOTS-1:0]       src0Neg,
  input  wire logic [SLOTS-1:0]       src1Neg,
  input  wire logic [SLOTS-1:0]       src2Neg,
  input  wire logic [SLOTS-1:0][1:0]  outputScaleField,
  input  wire logic [SLOTS-1:0]       clampEn,
  output logic                        resultValid,
  output logic      [SLOTS-1:0][31:0] result,
  output logic      [SLOTS-1:0]       slotHandled,
  output logic      [SLOTS-1:0]       passValid,
  output logic      [SLOTS-1:0][10:0] passOpcode
);

  function automatic opkind_type decodeOp(input logic three, input logic [10:0] opc);
    opkind_type k;
    k = K_NONE;
    if (three)
    begin
      case (opc)
        OPC3_LIT:      k = K_LIT;
        OPC3_SUM:      k = K_SUM;
        OPC3_HALF_SUM: k = K_HALF;
        OPC3_IEEE_SUM: k = K_IEEE_SUM;
        default:       k = K_NONE;
      endcase
    end
    else
    begin
      case (opc)
        OPC_MUL:        k = K_MUL;
        OPC_MUL_IEEE:   k = K_MUL_IEEE;
        OPC_F64_SCALAR: k = K_F64;
        OPC_F64_VECTOR: k = K_F64;
        OPC_CHAIN:      k = K_CHAIN;
        OPC_CHAIN_IEEE: k = K_CHAIN_IEE;
        OPC_CHAIN_SUM:  k = K_CHAIN_SUM;
        OPC_U24_LOW:    k = K_U24;
        default:        k = K_NONE;
      endcase
    end
    return k;
  endfunction

  function automatic logic signed [2:0] omDelta(input logic [1:0] om);
    case (om)
      OM_X2:   return 3'sd1;
      OM_X4:   return 3'sd2;
      OM_HALF: return -3'sd1;
      default: return 3'sd0;
    endcase
  endfunction

  // Exponent scaling; zero, inf and NaN pass untouched
  function automatic logic [31:0] scale32(input logic [31:0] v, input logic signed [2:0] dl);
    logic signed [9:0] ne;
    logic [31:0]       r;
    ne = $signed({2'b00, v[30:23]}) + 10'(dl);
    r  = v;
    if (v[30:23] != 8'h00 && v[30:23] != 8'hFF)
    begin
      if (ne >= 10'sd255)
        r = {v[31], 8'hFF, 23'h0};
      else if (ne <= 10'sd0)
        r = {v[31], 31'h0};
      else
        r = {v[31], ne[7:0], v[22:0]};
    end
    return r;
  endfunction

  function automatic logic [31:0] finish32(input logic [31:0] v, input logic [1:0] om,
                                           input logic cl);
    logic [31:0] r;
    r = scale32(v, omDelta(om));
    if (cl)
    begin
      if (r[31])
        r = RESULT_RST;
      else if (r[30:0] > ONE_SINGLE[30:0])
        r = ONE_SINGLE;
    end
    return r;
  endfunction

  function automatic logic [63:0] finish64(input logic [63:0] v, input logic [1:0] om,
                                           input logic cl);
    logic signed [12:0] ne;
    logic [63:0]        r;
    ne = $signed({2'b00, v[62:52]}) + 13'(omDelta(om));
    r  = v;
    if (v[62:52] != 11'h000 && v[62:52] != 11'h7FF)
    begin
      if (ne >= 13'sd2047)
        r = {v[63], 11'h7FF, 52'h0};
      else if (ne <= 13'sd0)
        r = {v[63], 63'h0};
      else
        r = {v[63], ne[10:0], v[51:0]};
    end
    if (cl)
    begin
      if (r[63])
        r = 64'h0;
      else if (r[62:0] > ONE_DOUBLE[62:0])
        r = ONE_DOUBLE;
    end
    return r;
  endfunction

  // Single-precision sum, denormals flushed, truncated like the product
  function automatic logic [31:0] fpAdd(input logic [31:0] a, input logic [31:0] b);
    logic [31:0]       x, y, r;
    logic [7:0]        d;
    logic [25:0]       mx, my;
    logic [26:0]       s;
    logic signed [9:0] e;
    x = a;
    y = b;
    r = RESULT_RST;
    if (a[30:0] < b[30:0])
    begin
      x = b;
      y = a;
    end
    d  = x[30:23] - y[30:23];
    mx = (x[30:23] == 8'h00) ? 26'h0 : {1'b1, x[22:0], 2'b00};
    my = (y[30:23] == 8'h00) ? 26'h0 : {1'b1, y[22:0], 2'b00};
    my = (d > 8'd25) ? 26'h0 : (my >> d);
    s  = (x[31] == y[31]) ? ({1'b0, mx} + {1'b0, my}) : ({1'b0, mx} - {1'b0, my});
    e  = $signed({2'b00, x[30:23]}) + 10'sd1;
    for (int i = 0; i < 27; i++)
    begin
      if (!s[26] && s != 27'h0)
      begin
        s = s << 1;
        e = e - 10'sd1;
      end
    end
    if (a[30:23] == 8'hFF && a[22:0] != 23'h0)
      r = a;
    else if (b[30:23] == 8'hFF && b[22:0] != 23'h0)
      r = b;
    else if (a[30:23] == 8'hFF && b[30:23] == 8'hFF && a[31] != b[31])
      r = QUIET_NAN_SINGLE;
    else if (a[30:23] == 8'hFF)
      r = a;
    else if (b[30:23] == 8'hFF)
      r = b;
    else if (mx == 26'h0)
      r = {a[31] & b[31], 31'h0};
    else if (s == 27'h0)
      r = RESULT_RST;
    else if (e >= 10'sd255)
      r = {x[31], 8'hFF, 23'h0};
    else if (e <= 10'sd0)
      r = {x[31], 31'h0};
    else
      r = {x[31], e[7:0], s[25:3]};
    return r;
  endfunction

  opkind_type              kind [SLOTS];
  logic [SLOTS-1:0][31:0]  s0n, s1n, s2n, opA, prodRaw, slotVal;
  logic [SLOTS-1:0]        ieeeMode;
  logic                    f64, litAny;
  logic [31:0]             litVal;
  logic [63:0]             a64, b64, p64, f64Fin;
  logic [1:0]              om64;

  logic                    resultValid_q, resultValid_d;
  logic [SLOTS-1:0][31:0]  result_q, result_d;
  logic [SLOTS-1:0]        slotHandled_q, slotHandled_d;
  logic [SLOTS-1:0]        passValid_q, passValid_d;
  logic [SLOTS-1:0][10:0]  passOpcode_q, passOpcode_d;

  for (genvar k = 0; k < SLOTS; k++) begin : g_slot
    assign kind[k] = decodeOp(opThree[k], opcodeField[k]);
    assign s0n[k]  = {src0[k][31] ^ src0Neg[k], src0[k][30:0]};
    assign s1n[k]  = {src1[k][31] ^ src1Neg[k], src1[k][30:0]};
    assign s2n[k]  = {src2[k][31] ^ src2Neg[k], src2[k][30:0]};
    assign ieeeMode[k] = (kind[k] == K_MUL_IEEE) || (kind[k] == K_CHAIN_IEE)
                      || (kind[k] == K_CHAIN_SUM) || (kind[k] == K_IEEE_SUM);
    if (k < 2) begin : g_chain
      // Raw neighbour product, before its output modifier and clamp
      assign opA[k] = (kind[k] == K_CHAIN || kind[k] == K_CHAIN_IEE || kind[k] == K_CHAIN_SUM)
                    ? prodRaw[k+2] : s0n[k];
    end
    else begin : g_plain
      assign opA[k] = s0n[k];
    end
    fp_product #(
      .EXP_W (8),
      .MAN_W (23)
    ) u_mul (
      .opA      (opA[k]),
      .opB      (s1n[k]),
      .ieeeZero (ieeeMode[k]),
      .prod     (prodRaw[k])
    );
  end

  // Double operands: sign carried in the high dword of slot Y
  assign a64  = {src0[SLOT_Y][31] ^ src0Neg[SLOT_Y], src0[SLOT_Y][30:0], src0[SLOT_X]};
  assign b64  = {src1[SLOT_Y][31] ^ src1Neg[SLOT_Y], src1[SLOT_Y][30:0], src1[SLOT_X]};
  assign f64  = issueValid && (kind[SLOT_X] == K_F64);
  assign om64 = (outputScaleField[SLOT_X] != OM_NONE) ? outputScaleField[SLOT_X]
                                                      : outputScaleField[SLOT_Z];
  assign f64Fin = finish64(p64, om64, clampEn[SLOT_X] | clampEn[SLOT_Z]);

  fp_product #(
    .EXP_W (11),
    .MAN_W (52)
  ) u_mul64 (
    .opA      (a64),
    .opB      (b64),
    .ieeeZero (1'b1),
    .prod     (p64)
  );

  // Lowest slot holding the lighting op supplies the replicated value
  always_comb
  begin
    litAny = 1'b0;
    litVal = RESULT_RST;
    for (int k = SLOTS - 1; k >= 0; k--)
    begin
      if (kind[k] == K_LIT)
      begin
        litAny = 1'b1;
        if (s1n[k] == NEG_MAX_SINGLE || s1n[k] == NEG_INF_SINGLE
            || (s1n[k][30:23] == 8'hFF && s1n[k][22:0] != 23'h0)
            || (s2n[k][30:23] == 8'hFF && s2n[k][22:0] != 23'h0)
            || s2n[k][31] || s2n[k][30:0] == 31'h0)
          litVal = NEG_MAX_SINGLE;
        else
          litVal = finish32(prodRaw[k], outputScaleField[k], clampEn[k]);
      end
    end
  end

  always_comb
  begin
    for (int k = 0; k < SLOTS; k++)
    begin
      case (kind[k])
        K_MUL, K_MUL_IEEE, K_CHAIN, K_CHAIN_IEE, K_CHAIN_SUM:
          slotVal[k] = finish32(prodRaw[k], outputScaleField[k], clampEn[k]);
        K_U24:
          slotVal[k] = 32'(src0[k][23:0] * src1[k][23:0]);
        K_SUM, K_IEEE_SUM:
          slotVal[k] = finish32(fpAdd(prodRaw[k], s2n[k]), outputScaleField[k],
                                clampEn[k]);
        K_HALF:
          slotVal[k] = finish32(scale32(fpAdd(prodRaw[k], s2n[k]), -3'sd1),
                                outputScaleField[k], clampEn[k]);
        default:
          slotVal[k] = RESULT_RST;
      endcase
    end
  end

  always_comb
  begin
    resultValid_d = issueValid;
    result_d      = result_q;
    slotHandled_d = '0;
    passValid_d   = '0;
    passOpcode_d  = passOpcode_q;
    if (issueValid)
    begin
      for (int k = 0; k < SLOTS; k++)
      begin
        passOpcode_d[k]  = opcodeField[k];
        slotHandled_d[k] = f64 || (kind[k] != K_NONE);
        passValid_d[k]   = !f64 && (kind[k] == K_NONE);
        if (f64)
          result_d[k] = (k % 2 == 0) ? f64Fin[31:0] : f64Fin[63:32];
        else if (litAny)
          result_d[k] = litVal;
        else if (kind[k] != K_NONE)
          result_d[k] = slotVal[k];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      resultValid_q <= 1'b0;
      result_q      <= {SLOTS{RESULT_RST}};
      slotHandled_q <= '0;
      passValid_q   <= '0;
      passOpcode_q  <= '0;
    end
    else
    begin
      resultValid_q <= resultValid_d;
      result_q      <= result_d;
      slotHandled_q <= slotHandled_d;
      passValid_q   <= passValid_d;
      passOpcode_q  <= passOpcode_d;
    end
  end

  assign resultValid = resultValid_q;
  assign result      = result_q;
  assign slotHandled = slotHandled_q;
  assign passValid   = passValid_q;
  assign passOpcode  = passOpcode_q;

  // Checks
  logic [31:0] u24Ref, wProd;
  assign u24Ref = 32'(src0[SLOT_W][23:0] * src1[SLOT_W][23:0]);
  assign wProd  = prodRaw[SLOT_W];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_u24;
    issueValid && kind[SLOT_W] == K_U24 && !litAny |=> result[SLOT_W] == $past(u24Ref);
  endproperty
  a_u24: assert property (p_u24) else $error("u24 product wrong");

  property p_legacy_zero;
    issueValid && kind[SLOT_X] == K_MUL && !litAny && src0[SLOT_X][30:23] == 8'h00
    |=> result[SLOT_X][30:0] == 31'h0;
  endproperty
  a_legacy_zero: assert property (p_legacy_zero) else $error("zero rule broken");

  property p_ieee_nan;
    issueValid && kind[SLOT_Z] == K_MUL_IEEE && !litAny && src0[SLOT_Z][30:0] == 31'h0
    && src1[SLOT_Z][30:0] == 31'h7F80_0000 && !clampEn[SLOT_Z]
    |=> result[SLOT_Z][30:23] == 8'hFF && result[SLOT_Z][22:0] != 23'h0;
  endproperty
  a_ieee_nan: assert property (p_ieee_nan) else $error("IEEE zero times inf not NaN");

  property p_f64_split;
    f64 |=> slotHandled == 4'hF && result[SLOT_X] == result[SLOT_Z]
            && result[SLOT_Y] == result[SLOT_W] && passValid == 4'h0;
  endproperty
  a_f64_split: assert property (p_f64_split) else $error("double result layout wrong");

  property p_f64_nan;
    f64 && src0[SLOT_Y] == 32'h7FF0_0000 && src0[SLOT_X] == 32'h0000_0000
    && src1[SLOT_Y][30:0] == 31'h0 && src1[SLOT_X] == 32'h0000_0000
    && !clampEn[SLOT_X] && !clampEn[SLOT_Z]
    |=> {result[SLOT_Y], result[SLOT_X]} == QUIET_NAN_DOUBLE;
  endproperty
  a_f64_nan: assert property (p_f64_nan) else $error("double inf times zero wrong");

  property p_pass;
    issueValid && !f64 && kind[SLOT_Z] == K_NONE
    |=> passValid[SLOT_Z] && !slotHandled[SLOT_Z]
        && passOpcode[SLOT_Z] == $past(opcodeField[SLOT_Z]);
  endproperty
  a_pass: assert property (p_pass) else $error("foreign opcode not passed");

  property p_lit_rep;
    issueValid && !f64 && litAny
    |=> result[0] == result[1] && result[1] == result[2] && result[2] == result[3];
  endproperty
  a_lit_rep: assert property (p_lit_rep) else $error("lighting result not replicated");

  property p_lit_negmax;
    issueValid && !f64 && kind[SLOT_X] == K_LIT && s2n[SLOT_X][31]
    |=> result[SLOT_X] == NEG_MAX_SINGLE;
  endproperty
  a_lit_negmax: assert property (p_lit_negmax) else $error("lighting clamp missed");

  property p_chain;
    issueValid && !litAny && kind[SLOT_Y] == K_CHAIN && s1n[SLOT_Y] == ONE_SINGLE
    && outputScaleField[SLOT_Y] == OM_NONE && !clampEn[SLOT_Y]
    |=> result[SLOT_Y] == $past(wProd);
  endproperty
  a_chain: assert property (p_chain) else $error("chained product wrong");

  property p_valid;
    issueValid |=> resultValid ##1 (resultValid == $past(issueValid));
  endproperty
  a_valid: assert property (p_valid) else $error("result valid timing wrong");

endmodule // gpu_multiply_alu

// ### pkg/mul_alu_pkg.sv
// Shared opcodes, operation kinds and float constants for the multiply ALU
package mul_alu_pkg;

  localparam int SLOTS = 4;
  localparam int OPC_W = 11;

  localparam int SLOT_X = 0;
  localparam int SLOT_Y = 1;
  localparam int SLOT_Z = 2;
  localparam int SLOT_W = 3;

  // Two-operand format opcodes
  localparam logic [10:0] OPC_MUL        = 11'h001;
  localparam logic [10:0] OPC_MUL_IEEE   = 11'h002;
  localparam logic [10:0] OPC_F64_SCALAR = 11'h01B;
  localparam logic [10:0] OPC_F64_VECTOR = 11'h0CA;
  localparam logic [10:0] OPC_CHAIN      = 11'h0D1;
  localparam logic [10:0] OPC_CHAIN_IEEE = 11'h0D2;
  localparam logic [10:0] OPC_CHAIN_SUM  = 11'h0D5;
  localparam logic [10:0] OPC_U24_LOW    = 11'h0B5;
  // Three-operand format opcodes
  localparam logic [10:0] OPC3_LIT       = 11'h01F;
  localparam logic [10:0] OPC3_SUM       = 11'h014;
  localparam logic [10:0] OPC3_HALF_SUM  = 11'h017;
  localparam logic [10:0] OPC3_IEEE_SUM  = 11'h018;

  localparam logic [63:0] QUIET_NAN_DOUBLE = 64'hFFF8_0000_0000_0000;
  localparam logic [31:0] QUIET_NAN_SINGLE = 32'hFFC0_0000;
  localparam logic [31:0] NEG_MAX_SINGLE   = 32'hFF7F_FFFF;
  localparam logic [31:0] NEG_INF_SINGLE   = 32'hFF80_0000;
  localparam logic [31:0] ONE_SINGLE       = 32'h3F80_0000;
  localparam logic [63:0] ONE_DOUBLE       = 64'h3FF0_0000_0000_0000;
  localparam logic [31:0] RESULT_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    OM_NONE = 2'b00,
    OM_X2   = 2'b01,
    OM_X4   = 2'b10,
    OM_HALF = 2'b11
  } output_scale_field_type;

  typedef enum logic [3:0] {
    K_NONE      = 4'b0000,
    K_MUL       = 4'b0001,
    K_MUL_IEEE  = 4'b0010,
    K_F64       = 4'b0011,
    K_CHAIN     = 4'b0100,
    K_CHAIN_IEE = 4'b0101,
    K_CHAIN_SUM = 4'b0110,
    K_U24       = 4'b0111,
    K_LIT       = 4'b1000,
    K_SUM       = 4'b1001,
    K_HALF      = 4'b1010,
    K_IEEE_SUM  = 4'b1011
  } opkind_type;

endpackage

// ### test/group_issuer.sv
// Sequencer model that stages one ALU group and issues it for one cycle
`timescale 1ns/10ps
module group_issuer
  import mul_alu_pkg::*;
(
  input  wire logic                   sys_clk,
  output logic                        issueValid,
  output logic      [SLOTS-1:0]       opThree,
  output logic      [SLOTS-1:0][10:0] opcodeField,
  output logic      [SLOTS-1:0][31:0] src0,
  output logic      [SLOTS-1:0][31:0] src1,
  output logic      [SLOTS-1:0][31:0] src2,
  output logic      [SLOTS-1:0]       src0Neg,
  output logic      [SLOTS-1:0]       src1Neg,
  output logic      [SLOTS-1:0]       src2Neg,
  output logic      [SLOTS-1:0][1:0]  outputScaleField,
  output logic      [SLOTS-1:0]       clampEn
);
  logic [SLOTS-1:0]       thrS;
  logic [SLOTS-1:0][10:0] opcS;
  logic [SLOTS-1:0][31:0] aS;
  logic [SLOTS-1:0][31:0] bS;
  logic [SLOTS-1:0][31:0] cS;
  logic [SLOTS-1:0]       negS;
  logic [SLOTS-1:0][1:0]  sclS;
  logic [SLOTS-1:0]       clS;

  // Called once by the bench process, so every line has a single driver
  task automatic idle();
    {issueValid, opThree, opcodeField, src0, src1, src2} <= '0;
    {src0Neg, src1Neg, src2Neg, outputScaleField, clampEn} <= '0;
  endtask

  // Idle slots carry a no-op, which lies outside the multiply family
  task automatic clear();
    thrS = '0;
    aS   = '0;
    bS   = '0;
    cS   = '0;
    negS = '0;
    sclS = '0;
    clS  = '0;
    for (int s = 0; s < SLOTS; s++)
      opcS[s] = 11'h01A;
  endtask

  task automatic put(input int s, input logic t, input logic [10:0] op,
                     input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    thrS[s] = t;
    opcS[s] = op;
    aS[s]   = a;
    bS[s]   = b;
    cS[s]   = c;
  endtask

  task automatic mods(input int s, input logic n, input logic [1:0] sc);
    negS[s] = n;
    sclS[s] = sc;
  endtask

  task automatic clamp(input int s);
    clS[s] = 1'b1;
  endtask

  task automatic send();
    @(posedge sys_clk);
    issueValid       <= 1'b1;
    opThree          <= thrS;
    opcodeField      <= opcS;
    src0             <= aS;
    src1             <= bS;
    src2             <= cS;
    src0Neg          <= negS;
    outputScaleField <= sclS;
    clampEn          <= clS;
    @(posedge sys_clk);
    issueValid <= 1'b0;
    // Operands are only held while issued, so stale values must not look valid
    src0       <= ~aS;
    src1       <= ~bS;
    src2       <= ~cS;
    #1;
  endtask
endmodule // group_issuer

// ### test/tb_gpu_multiply_alu.sv
// Self-checking testbench for the multiply-family ALU block
`timescale 1ns/10ps
module tb_gpu_multiply_alu;
  import mul_alu_pkg::*;
  localparam logic [31:0] F2  = 32'h4000_0000;
  localparam logic [31:0] F3  = 32'h4040_0000;
  localparam logic [31:0] INF = 32'h7F80_0000;
  logic                   sys_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   iv;
  logic [SLOTS-1:0]       thr;
  logic [SLOTS-1:0][10:0] opc;
  logic [SLOTS-1:0][31:0] a;
  logic [SLOTS-1:0][31:0] b;
  logic [SLOTS-1:0][31:0] c;
  logic [SLOTS-1:0]       n0;
  logic [SLOTS-1:0]       n1;
  logic [SLOTS-1:0]       n2;
  logic [SLOTS-1:0][1:0]  sc;
  logic [SLOTS-1:0]       cl;
  logic                   resultValid;
  logic [SLOTS-1:0][31:0] result;
  logic [SLOTS-1:0]       slotHandled;
  logic [SLOTS-1:0]       passValid;
  logic [SLOTS-1:0][10:0] passOpcode;
  int                     bad_count = 0;
  int                     num_checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  group_issuer i_group_issuer (.sys_clk(sys_clk), .issueValid(iv), .opThree(thr),
    .opcodeField(opc), .src0(a), .src1(b), .src2(c), .src0Neg(n0), .src1Neg(n1),
    .src2Neg(n2), .outputScaleField(sc), .clampEn(cl));

  gpu_multiply_alu i_gpu_multiply_alu (.sys_clk(sys_clk), .rstn(rstn), .issueValid(iv),
    .opThree(thr), .opcodeField(opc), .src0(a), .src1(b), .src2(c), .src0Neg(n0),
    .src1Neg(n1), .src2Neg(n2), .outputScaleField(sc), .clampEn(cl),
    .resultValid(resultValid), .result(result), .slotHandled(slotHandled),
    .passValid(passValid), .passOpcode(passOpcode));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic test_mul();
    i_group_issuer.clear();
    i_group_issuer.put(SLOT_X, 1'b0, OPC_MUL, '0, INF, '0);
    i_group_issuer.put(SLOT_Y, 1'b0, OPC_MUL, F2, F3, '0);
    i_group_issuer.put(SLOT_Z, 1'b0, OPC_MUL_IEEE, '0, INF, '0);
    i_group_issuer.send();
    chk(resultValid, 1'b1);
    chk(result[0], 32'h0000_0000);
    chk(result[1], 32'h40C0_0000);
    chk(result[2][30:22], 9'h1FF);
    chk({slotHandled, passValid, passOpcode[3]}, {8'h78, 11'h01A});
    @(posedge sys_clk);
    #1;
    chk(resultValid, 1'b0);
    $display("single product test done");
  endtask

  task automatic test_double();
    logic [31:0] hi;
    for (int i = 0; i < 4; i++)
    begin
      i_group_issuer.clear();
      for (int s = 0; s < SLOTS; s++)
        i_group_issuer.put(s, 1'b0, (i == 0) ? OPC_F64_SCALAR : OPC_F64_VECTOR, '0, '0, '0);
      i_group_issuer.put(SLOT_Y, 1'b0, OPC_F64_VECTOR, (i == 3) ? 32'h7FF0_0000
                         : 32'h4008_0000, (i == 3) ? 32'h0 : 32'h4018_0000, '0);
      // Scale in W must be ignored, scale in X must apply
      i_group_issuer.mods(SLOT_Y, i == 1, OM_NONE);
      i_group_issuer.mods(SLOT_W, 1'b0, OM_X2);
      i_group_issuer.mods(SLOT_X, 1'b0, (i == 2) ? OM_X2 : OM_NONE);
      hi = (i == 1) ? 32'hC032_0000 : (i == 2) ? 32'h4042_0000 : 32'h4032_0000;
      i_group_issuer.send();
      if (i == 3)
        chk({result[1], result[0]}, QUIET_NAN_DOUBLE);
      else
        chk({result[1], result[0]}, {hi, 32'h0});
      chk({result[3], result[2]}, (i == 3) ? QUIET_NAN_DOUBLE : {hi, 32'h0});
      chk(slotHandled, 4'hF);
    end
    $display("double product test done");
  endtask

  task automatic test_chain();
    i_group_issuer.clear();
    // Feeding slots hold plain products
    i_group_issuer.put(SLOT_W, 1'b0, OPC_MUL, F2, F3, '0);
    i_group_issuer.mods(SLOT_W, 1'b0, OM_X2);
    i_group_issuer.clamp(SLOT_W);
    i_group_issuer.put(SLOT_Y, 1'b0, OPC_CHAIN, '0, 32'h3F00_0000, '0);
    i_group_issuer.put(SLOT_Z, 1'b0, OPC_MUL, '0, INF, '0);
    i_group_issuer.put(SLOT_X, 1'b0, OPC_CHAIN_IEEE, '0, INF, '0);
    i_group_issuer.send();
    chk(result[3], ONE_SINGLE);
    chk(result[1], F3);
    chk(result[0][30:22], 9'h1FF);
    i_group_issuer.clear();
    i_group_issuer.put(SLOT_Z, 1'b0, OPC_MUL, F2, F2, '0);
    i_group_issuer.put(SLOT_X, 1'b0, OPC_CHAIN_SUM, '0, F2, '0);
    i_group_issuer.put(SLOT_W, 1'b0, OPC_MUL, F2, F3, '0);
    i_group_issuer.put(SLOT_Y, 1'b0, OPC_CHAIN, '0, ONE_SINGLE, '0);
    i_group_issuer.send();
    chk(result[0], 32'h4100_0000);
    chk(result[1], 32'h40C0_0000);
    $display("chained product test done");
  endtask

  task automatic test_three();
    i_group_issuer.clear();
    i_group_issuer.put(SLOT_X, 1'b1, OPC3_SUM, F2, F3, ONE_SINGLE);
    i_group_issuer.put(SLOT_Y, 1'b1, OPC3_HALF_SUM, F2, F3, ONE_SINGLE);
    i_group_issuer.put(SLOT_Z, 1'b1, OPC3_IEEE_SUM, '0, INF, ONE_SINGLE);
    i_group_issuer.put(SLOT_W, 1'b0, OPC_U24_LOW, 32'h0100_0003, 32'hFF00_0005, '0);
    i_group_issuer.send();
    chk(result[0], 32'h40E0_0000);
    chk(result[1], 32'h4060_0000);
    chk(result[2][30:22], 9'h1FF);
    chk(result[3], 32'h0000_000F);
    $display("product sum test done");
  endtask

  task automatic test_lit();
    for (int i = 0; i < 4; i++)
    begin
      i_group_issuer.clear();
      i_group_issuer.put(SLOT_X, 1'b1, OPC3_LIT, F2, (i == 2) ? NEG_INF_SINGLE : F3,
                         (i == 1) ? 32'h0 : (i == 3) ? 32'hBF80_0000 : ONE_SINGLE);
      i_group_issuer.send();
      for (int s = 0; s < SLOTS; s++)
        chk(result[s], (i == 0) ? 32'h40C0_0000 : NEG_MAX_SINGLE);
    end
    $display("lighting product test done");
  endtask

  initial
  begin
    i_group_issuer.idle();
    i_group_issuer.clear();
    repeat (20) @(posedge sys_clk);
    #1;
    chk({resultValid, slotHandled, passValid}, '0);
    chk(result[1:0], '0);
    chk(result[3:2], '0);
    chk(passOpcode, '0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    test_mul();
    test_double();
    test_chain();
    test_three();
    test_lit();
    finish_test();
  end

  // Cuts a hang short; every wait above is a fixed count of edges
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule // tb_gpu_multiply_alu
